// file: logic/lgd_pkg.sv
// Purpose: constants and carriers for the glyph and icon display engine
// Assumes: mclk at 40 MHz, one clock domain
// Notes:   no software-visible registers; controls arrive as ports
`default_nettype none

package lgd_pkg;
  localparam int          CLK_HZ          = 40_000_000;
  localparam int          BUSY_MS         = 10;
  localparam int          BUSY_CYCLES     = CLK_HZ / 1000 * BUSY_MS;
  localparam int          BLINK_CYCLES    = 16_000_000;
  localparam int          DIGITS          = 12;
  localparam int          ROWS            = 18;
  localparam int          COLS            = 60;
  localparam int          GLYPH_WORDS     = 32;
  localparam int          PIX             = 5;
  localparam int          ICON_ROW_A      = 16;
  localparam int          ICON_ROW_B      = 17;
  localparam logic [4:0]  ICON_FIRST      = 5'h14;
  localparam logic [4:0]  ICON_LAST       = 5'h1F;
  localparam logic [6:0]  LINE1_BASE      = 7'h00;
  localparam logic [6:0]  LINE2_BASE      = 7'h40;
  localparam logic [3:0]  USER_CODE_HI    = 4'h0;
  localparam logic [2:0]  CURSOR_ROW      = 3'h7;
  localparam logic [4:0]  PIX_RESET       = 5'h00;

  typedef struct packed {
    logic       we;
    logic [4:0] addr;
    logic [4:0] data;
  } lgd_glyph_wr_s;

  typedef struct packed {
    logic       display_on;
    logic       cursor_on;
    logic       blink_on;
  } lgd_disp_ctl_s;
endpackage

`default_nettype wire

// file: logic/lgd_shift_latch.sv
// Purpose: serial column shift register with whole-line latch
// Assumes: one bit shifted per load strobe, first bit lands in column 60
// Notes:   outputs change only on latch
`default_nettype none

module lgd_shift_latch
  import lgd_pkg::*;
#(
  parameter int WIDTH = COLS
)(
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             shift_en,
  input  wire logic             shift_bit,
  input  wire logic             latch_en,
  output logic [WIDTH-1:0]      cols
);
  logic [WIDTH-1:0] shreg;

  // ---------------------------------------------------------------
  // shift chain
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      shreg <= '0;
    else if (shift_en)
      shreg <= {shreg[WIDTH-2:0], shift_bit};
  end

  // ---------------------------------------------------------------
  // latch
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      cols <= '0;
    else if (latch_en)
      cols <= shreg;
  end
endmodule

`default_nettype wire

// file: logic/lgd_engine.sv
// Purpose: glyph, icon, cursor and scan engine of a 12x2 character display
// Assumes: text memory read port external; one refresh fetch per cycle
// Notes:   host writes use their own port; refresh reads never stall them
`default_nettype none

module lgd_engine
  import lgd_pkg::*;
#(
  parameter int BUSY_LEN  = BUSY_CYCLES,
  parameter int BLINK_LEN = BLINK_CYCLES
)(
  input  wire logic          mclk,
  input  wire logic          reset_n,
  input  wire logic          soft_init,
  input  wire lgd_glyph_wr_s glyph_wr,
  input  wire lgd_disp_ctl_s disp_ctl,
  input  wire logic          disp_ctl_we,
  input  wire logic [6:0]    address_pointer,
  input  wire logic [4:0]    shift_offset,
  input  wire logic [7:0]    text_code,
  input  wire logic [34:0]   rom_rows,
  output logic [6:0]         text_addr,
  output logic               busy_indicator,
  output logic [ROWS-1:0]    row_select,
  output logic [1:0]         icon_row_drive,
  output logic [COLS-1:0]    column_drive
);
  typedef enum logic [1:0] {ST_LOAD, ST_LATCH} lgd_scan_e;

  logic [PIX-1:0]  glyph_mem [GLYPH_WORDS];
  logic [PIX-1:0]  icon_mem  [12];
  lgd_disp_ctl_s   ctl;
  lgd_scan_e       state;
  logic [31:0]     busy_cnt;
  logic [31:0]     blink_cnt;
  logic            blink_phase;
  logic [4:0]      scan_row;
  logic [5:0]      bit_idx;
  logic [2:0]      pix_idx;
  logic [2:0]      glyph_row;
  logic [6:0]      here_addr;
  logic            is_user;
  logic [4:0]      glyph_addr;
  logic [PIX-1:0]  row_pix;
  logic            cur_here;
  logic            icon_scan;
  logic            bit_out;
  logic            shift_en;
  logic            latch_en;
  logic [3:0]      icon_word;
  logic [2:0]      icon_bit;
  logic [6:0]      next_text_addr;
  logic [5:0]      col_pos;

  // ---------------------------------------------------------------
  // busy period after reset
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      busy_cnt <= '0;
    else if (busy_cnt < 32'(BUSY_LEN))
      busy_cnt <= busy_cnt + 32'd1;
  end

  assign busy_indicator = (busy_cnt < 32'(BUSY_LEN));

  // ---------------------------------------------------------------
  // display control and blink timer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      ctl <= '0;
    else if (disp_ctl_we)
      ctl <= disp_ctl;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      blink_cnt   <= '0;
      blink_phase <= 1'b0;
    end
    else if (blink_cnt >= 32'(BLINK_LEN - 1))
    begin
      blink_cnt   <= '0;
      blink_phase <= ~blink_phase;
    end
    else
      blink_cnt <= blink_cnt + 32'd1;
  end

  // ---------------------------------------------------------------
  // glyph memory: host port, cleared only by software init
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (soft_init)
    begin
      for (int i = 0; i < GLYPH_WORDS; i++)
        glyph_mem[i] <= PIX_RESET;
    end
    else if (glyph_wr.we)
      glyph_mem[glyph_wr.addr] <= glyph_wr.data;
  end

  // icon copy follows glyph writes from ICON_FIRST up; cleared by software init
  always_ff @(posedge mclk)
  begin
    if (soft_init)
    begin
      for (int i = 0; i < 12; i++)
        icon_mem[i] <= PIX_RESET;
    end
    else if (glyph_wr.we && glyph_wr.addr >= ICON_FIRST)
      icon_mem[4'(glyph_wr.addr - ICON_FIRST)] <= glyph_wr.data;
  end

  // ---------------------------------------------------------------
  // scan sequencer: refresh side, independent of host port
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state    <= ST_LOAD;
      bit_idx  <= '0;
      scan_row <= '0;
    end
    else
    begin
      case (state)
        ST_LOAD:
        begin
          if (bit_idx == 6'(COLS - 1))
          begin
            bit_idx <= '0;
            state   <= ST_LATCH;
          end
          else
            bit_idx <= bit_idx + 6'd1;
        end
        ST_LATCH:
        begin
          state    <= ST_LOAD;
          scan_row <= (scan_row == 5'(ROWS - 1)) ? 5'd0 : scan_row + 5'd1;
        end
        default:
          state <= ST_LOAD;
      endcase
    end
  end

  // row being loaded into the column chain
  logic [4:0] load_row;
  assign load_row = (scan_row == 5'(ROWS - 1)) ? 5'd0 : scan_row + 5'd1;

  // text address of a column bit of a scan row
  function automatic logic [6:0] text_addr_of(input logic [5:0] idx,
                                              input logic [4:0] row,
                                              input logic [4:0] offs);
    logic [5:0] pos;
    logic [3:0] dig;
    pos = 6'(COLS - 1) - idx;
    dig = 4'(pos / 6'd5);
    return ((row >= 5'd8) ? LINE2_BASE : LINE1_BASE)
           + 7'((5'(dig) + offs) % 5'(DIGITS));
  endfunction

  // fetch runs one bit ahead so text_code matches the bit in hand
  logic [5:0] ahead_idx;
  logic [4:0] ahead_row;
  always_comb
  begin
    ahead_idx = bit_idx + 6'd1;
    ahead_row = load_row;
    if (state == ST_LATCH)
    begin
      ahead_idx = '0;
      ahead_row = (load_row == 5'(ROWS - 1)) ? 5'd0 : load_row + 5'd1;
    end
  end

  // ---------------------------------------------------------------
  // column bit fetch for the row being loaded
  // ---------------------------------------------------------------
  always_comb
  begin
    col_pos   = 6'(COLS - 1) - bit_idx;
    pix_idx   = 3'(col_pos % 6'd5);
    icon_scan = (load_row >= 5'(ICON_ROW_A));
    glyph_row = load_row[2:0];
    next_text_addr = text_addr_of(ahead_idx, ahead_row, shift_offset);
    here_addr  = text_addr_of(bit_idx, load_row, shift_offset);
    is_user    = (text_code[7:4] == USER_CODE_HI);
    glyph_addr = {text_code[1:0], glyph_row};
    if (is_user)
      row_pix = glyph_mem[glyph_addr];
    else if (glyph_row == CURSOR_ROW)
      row_pix = '0;
    else
      row_pix = rom_rows[PIX * int'(glyph_row) +: PIX];
    cur_here   = (address_pointer == here_addr);
    if (ctl.cursor_on && cur_here && glyph_row == CURSOR_ROW)
      row_pix = row_pix | {PIX{1'b1}};
    if (ctl.blink_on && cur_here && blink_phase)
      row_pix = '0;
    icon_word = 4'd11 - 4'(col_pos / 6'd5);
    icon_bit  = 3'(col_pos % 6'd5);
    if (!ctl.display_on)
      bit_out = 1'b0;
    else if (icon_scan)
      bit_out = icon_mem[icon_word][icon_bit];
    else
      bit_out = row_pix[3'd4 - pix_idx];
    shift_en = (state == ST_LOAD);
    latch_en = (state == ST_LATCH);
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      text_addr <= '0;
    else
      text_addr <= next_text_addr;
  end

  // ---------------------------------------------------------------
  // row drivers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      row_select <= '0;
    else if (latch_en)
      row_select <= ROWS'(1) << load_row;
  end

  assign icon_row_drive = row_select[ICON_ROW_B:ICON_ROW_A];

  lgd_shift_latch #(
    .WIDTH (COLS)
  ) u_cols (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .shift_en  (shift_en),
    .shift_bit (bit_out),
    .latch_en  (latch_en),
    .cols      (column_drive)
  );
endmodule

`default_nettype wire

// file: tb/lgd_engine_assertions.sv
// Purpose: port checks of the display engine
// Assumes: one clock, synchronous reset
// Notes:   bound to lgd_engine
`default_nettype none

module lgd_engine_assertions
  import lgd_pkg::*;
#(
  parameter int BUSY_LEN  = BUSY_CYCLES,
  parameter int BLINK_LEN = BLINK_CYCLES
)(
  input  wire logic            mclk,
  input  wire logic            reset_n,
  input  wire logic            busy_indicator,
  input  wire logic [ROWS-1:0] row_select,
  input  wire logic [1:0]      icon_row_drive,
  input  wire logic [COLS-1:0] column_drive
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // cycle counters
  // ----------------------------------------
  int up;
  int gap;
  default clocking cb @(posedge mclk); endclocking
  always_ff @(posedge mclk)
  begin
    if (!reset_n) up <= 0;
    else if (up < BUSY_LEN + 4) up <= up + 1;
  end
  always_ff @(posedge mclk)
  begin
    if (!reset_n || $changed(row_select)) gap <= 0;
    else if (gap < 1000) gap <= gap + 1;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  AST_BUSY_RST: assert property (!reset_n |=> busy_indicator)
    else $error("busy low in reset");
  AST_BUSY_HOLD: assert property (disable iff (!reset_n)
    up < BUSY_LEN |-> busy_indicator) else $error("busy dropped early");
  AST_BUSY_DROP: assert property (disable iff (!reset_n)
    up >= BUSY_LEN |-> !busy_indicator) else $error("busy stuck");
  AST_RST_DRIVE: assert property (!reset_n |=> row_select == '0 && column_drive == '0)
    else $error("drivers not cleared in reset");
  AST_ROW_ONEHOT: assert property (disable iff (!reset_n) $onehot0(row_select))
    else $error("several rows selected");
  AST_ICON_ROWS: assert property (disable iff (!reset_n)
    icon_row_drive == row_select[17:16]) else $error("icon rows differ");
  AST_LATCH_LINE: assert property (disable iff (!reset_n)
    $changed(column_drive) |-> $changed(row_select)) else $error("columns moved mid line");
  AST_LINE_LEN: assert property (disable iff (!reset_n)
    $changed(row_select) && $past(row_select) != '0 && row_select != '0 |-> gap == 60)
    else $error("line length wrong");
  AST_SCAN_ORDER: assert property (disable iff (!reset_n)
    $changed(row_select) && $past(row_select) != '0 && row_select != '0
    |-> row_select == ($past(row_select[17]) ? 18'h00001 : $past(row_select) << 1))
    else $error("rows out of order");
endmodule

bind lgd_engine lgd_engine_assertions #(.BUSY_LEN(BUSY_LEN), .BLINK_LEN(BLINK_LEN)) u_chk (
  .mclk(mclk), .reset_n(reset_n), .busy_indicator(busy_indicator),
  .row_select(row_select), .icon_row_drive(icon_row_drive), .column_drive(column_drive));

`default_nettype wire

// file: tb/lgd_text_mem.sv
// Purpose: text memory and fixed glyph rows facing the engine
// Assumes: combinational read, fixed rows all dark
// Notes:   written by the bench through its own port
`default_nettype none

module lgd_text_mem
(
  input  wire logic        mclk,
  input  wire logic        we,
  input  wire logic [6:0]  waddr,
  input  wire logic [7:0]  wdata,
  input  wire logic [6:0]  text_addr,
  output logic [7:0]       text_code,
  output logic [34:0]      rom_rows
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [128];
  initial foreach (mem[i]) mem[i] = 8'h20;
  always @(posedge mclk) if (we) mem[waddr] <= wdata;
  assign text_code = mem[text_addr];
  assign rom_rows  = 35'h0;
endmodule

`default_nettype wire

// file: tb/lgd_engine_test.sv
// Purpose: self-checking bench of the display engine
// Assumes: short busy and blink counts
// Notes:   samples at falling edge
`default_nettype none

module lgd_engine_test
  import lgd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic            mclk, reset_n, soft_init, disp_ctl_we, mem_we, busy_indicator;
  lgd_glyph_wr_s   glyph_wr;
  lgd_disp_ctl_s   disp_ctl;
  logic [6:0]      address_pointer, text_addr, mem_addr;
  logic [4:0]      shift_offset;
  logic [7:0]      text_code, mem_data;
  logic [34:0]     rom_rows;
  logic [ROWS-1:0] row_select;
  logic [1:0]      icon_row_drive;
  logic [COLS-1:0] column_drive, icons;
  int              bad_count, n_tests;
  lgd_engine #(.BUSY_LEN(20), .BLINK_LEN(2196)) u_dut (.mclk(mclk), .reset_n(reset_n),
    .soft_init(soft_init), .glyph_wr(glyph_wr), .disp_ctl(disp_ctl),
    .disp_ctl_we(disp_ctl_we), .address_pointer(address_pointer),
    .shift_offset(shift_offset), .text_code(text_code), .rom_rows(rom_rows),
    .text_addr(text_addr), .busy_indicator(busy_indicator), .row_select(row_select),
    .icon_row_drive(icon_row_drive), .column_drive(column_drive));
  lgd_text_mem u_mem (.mclk(mclk), .we(mem_we), .waddr(mem_addr), .wdata(mem_data),
    .text_addr(text_addr), .text_code(text_code), .rom_rows(rom_rows));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    n_tests++;
    if (seen !== want)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic gwr(input logic [4:0] a, input logic [4:0] d);
    @(posedge mclk) glyph_wr <= '{1'b1, a, d};
    @(posedge mclk) glyph_wr.we <= 1'b0;
  endtask
  task automatic line1(input logic [7:0] c);
    for (int i = 0; i < 12; i++)
    begin
      @(posedge mclk) {mem_we, mem_addr, mem_data} <= {1'b1, 7'(i), c};
    end
    @(posedge mclk) mem_we <= 1'b0;
  endtask
  task automatic ctl(input logic d, input logic c, input logic b = 1'b0);
    @(posedge mclk) {disp_ctl, disp_ctl_we} <= {d, c, b, 1'b1};
    @(posedge mclk) disp_ctl_we <= 1'b0;
  endtask
  task automatic frm(input int r, input int n = 2);
    repeat (n)
    begin
      @(negedge mclk) while (row_select[r] === 1'b1) @(negedge mclk);
      while (row_select[r] !== 1'b1) @(negedge mclk);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_icon();
    icons = '0;
    for (int k = 0; k < 12; k++)
    begin
      gwr(5'h14 + 5'(k), 5'(k + 1));
      icons[59 - 5 * k -: 5] = 5'(k + 1);
    end
    frm(16);
    check(column_drive, icons);
    @(posedge mclk) shift_offset <= 5'h03;
    frm(16);
    check(column_drive, icons);
  endtask
  task automatic t_glyph();
    logic [7:0] codes [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h0D, 8'h10};
    for (int i = 0; i < 8; i++) gwr(5'(i), 5'h1F);
    for (int i = 0; i < 6; i++)
    begin
      line1(codes[i]);
      frm(2);
      check(column_drive, (i < 4) ? {60{1'b1}} : 60'h0);
    end
  endtask
  task automatic t_cursor();
    ctl(1'b1, 1'b1);
    @(posedge mclk) address_pointer <= 7'h08;
    frm(7);
    check($countones(column_drive), 5);
    @(posedge mclk) address_pointer <= 7'h48;
    frm(15);
    check($countones(column_drive), 5);
    line1(8'h01);
    @(posedge mclk) address_pointer <= 7'h08;
    gwr(5'h0F, 5'h11);
    frm(7);
    check($countones(column_drive), 27);
  endtask
  task automatic t_blink();
    int n_dark;
    int n_lit;
    n_dark = 0;
    n_lit = 0;
    line1(8'h00);
    ctl(1'b1, 1'b0, 1'b1);
    frm(2);
    for (int i = 0; i < 6; i++)
    begin
      frm(2, 1);
      check(($countones(column_drive) == 55) || ($countones(column_drive) == 60), 1'b1);
      if ($countones(column_drive) == 55)
        n_dark++;
      else
        n_lit++;
    end
    check((n_dark > 0) && (n_lit > 0), 1'b1);
  endtask
  task automatic t_off();
    ctl(1'b0, 1'b0);
    frm(16);
    check(column_drive, 60'h0);
    ctl(1'b1, 1'b0);
    frm(16);
    check(column_drive, icons);
    @(posedge mclk) soft_init <= 1'b1;
    @(posedge mclk) soft_init <= 1'b0;
    frm(16);
    check(column_drive, 60'h0);
  endtask
  // ----------------------------------------
  // main
  // ----------------------------------------
  initial
  begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  initial
  begin
    repeat (90000) @(posedge mclk);
    bad_count++;
    print_verdict();
  end
  initial
  begin
    {reset_n, disp_ctl_we, mem_we, mem_addr, mem_data} = '0;
    soft_init = 1'b1;
    glyph_wr = '0;
    disp_ctl = 3'b100;
    address_pointer = 7'h7F;
    shift_offset = 5'h00;
    repeat (10) @(posedge mclk);
    @(negedge mclk) check(busy_indicator, 1'b1);
    @(posedge mclk) {reset_n, soft_init} <= 2'b10;
    repeat (15) @(negedge mclk);
    check(busy_indicator, 1'b1);
    repeat (10) @(negedge mclk);
    check(busy_indicator, 1'b0);
    ctl(1'b1, 1'b0);
    t_icon();
    t_glyph();
    t_cursor();
    t_blink();
    t_off();
    print_verdict();
  end
endmodule

`default_nettype wire
